// file: spo_pkg.sv
`default_nettype none
package spo_pkg;

    // ----------------------------------------
    // Register addresses
    // ----------------------------------------
    localparam logic [7:0] SPO_ADDR_CTRL     = 8'hC0;
    localparam logic [7:0] SPO_ADDR_BUF      = 8'hC1;
    localparam logic [7:0] SPO_ADDR_IRQ_STAT = 8'hC2;
    localparam logic [7:0] SPO_ADDR_IRQ_MASK = 8'hC3;
    localparam logic [7:0] SPO_ADDR_CFG      = 8'hC4;

    // ----------------------------------------
    // Reset values and field positions
    // ----------------------------------------
    localparam logic [7:0] SPO_CTRL_RST       = 8'h00;
    localparam logic [7:0] SPO_BUF_RST        = 8'h00;
    localparam logic [1:0] SPO_IRQ_RST        = 2'h0;
    localparam logic       SPO_CFG_RST        = 1'b0;
    localparam int         SPO_IRQ_RX_POS     = 0;
    localparam int         SPO_IRQ_TX_POS     = 1;
    localparam int         SPO_CFG_DOUBLE_POS = 0;

    // ----------------------------------------
    // Timing counts, in system clocks, ticks and bits
    // ----------------------------------------
    localparam int SPO_SYNC_SLOW_CLKS = 12;
    localparam int SPO_SYNC_FAST_CLKS = 4;
    localparam int SPO_M2_SLOW_CLKS   = 64;
    localparam int SPO_M2_FAST_CLKS   = 32;
    localparam int SPO_TICKS_PER_BIT  = 16;
    localparam logic [3:0] SPO_SYNC_SLOW_LAST = 4'(SPO_SYNC_SLOW_CLKS - 1);
    localparam logic [3:0] SPO_SYNC_FAST_LAST = 4'(SPO_SYNC_FAST_CLKS - 1);
    localparam logic [3:0] SPO_SYNC_SLOW_RISE = 4'(SPO_SYNC_SLOW_CLKS / 2 - 1);
    localparam logic [3:0] SPO_SYNC_FAST_RISE = 4'(SPO_SYNC_FAST_CLKS / 2 - 1);
    localparam logic [1:0] SPO_M2_SLOW_PRE =
        2'(SPO_M2_SLOW_CLKS / SPO_TICKS_PER_BIT - 1);
    localparam logic [1:0] SPO_M2_FAST_PRE =
        2'(SPO_M2_FAST_CLKS / SPO_TICKS_PER_BIT - 1);
    localparam logic [3:0] SPO_TICK_LAST   = 4'(SPO_TICKS_PER_BIT - 1);
    localparam logic [3:0] SPO_SAMPLE_TICK = 4'(SPO_TICKS_PER_BIT / 2 - 1);
    localparam logic [3:0] SPO_FRAME10_LAST = 4'h9;
    localparam logic [3:0] SPO_FRAME11_LAST = 4'hA;
    localparam logic [3:0] SPO_RX_LAST      = 4'h8;
    localparam logic [3:0] SPO_SYNC_LAST    = 4'h7;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef struct packed {
        logic mode_select_bit_a;
        logic mode_select_bit_b;
        logic multiproc_or_rate_select;
        logic receive_enable;
        logic ninth_transmit_bit;
        logic ninth_receive_bit;
        logic transmit_done_flag;
        logic receive_done_flag;
    } spo_ctrl_s;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       write;
        logic       read;
    } spo_bus_req_s;

    typedef enum logic [1:0] {SPO_TX_IDLE, SPO_TX_ASYNC, SPO_TX_SYNC} spo_tx_state_e;
    typedef enum logic [1:0] {SPO_RX_IDLE, SPO_RX_START, SPO_RX_DATA, SPO_RX_SYNC} spo_rx_state_e;

    typedef struct packed {
        spo_ctrl_s     ctl;
        logic [7:0]    rx_buf;
        logic [1:0]    irq_stat;
        logic [1:0]    irq_mask;
        logic          dbl;
        logic [7:0]    rdata;
        logic          sync1;
        logic          sync2;
        logic          rxd_prev;
        logic [1:0]    pre_cnt;
        logic          ov_div;
        spo_tx_state_e tx_st;
        logic [10:0]   tx_shift;
        logic [3:0]    tx_bits;
        logic [3:0]    tx_tick;
        logic [3:0]    tx_clk;
        logic          txd;
        logic          rxd_out;
        logic          rxd_oe;
        spo_rx_state_e rx_st;
        logic [8:0]    rx_shift;
        logic [3:0]    rx_bits;
        logic [3:0]    rx_tick;
        logic [3:0]    rx_clk;
    } spo_state_s;

endpackage
`default_nettype wire

// file: spo_serial_port.sv
`timescale 1ns/1ns
`default_nettype none

// How it works
// - Mode bits pick sync 12/4-clock shift, 10-bit or 11-bit async frames.
// - Async frames carry one start bit, one stop bit, eight or nine data bits.
// - Modes 1 and 3 time their bits from Timer 1 overflow pulses.
// - Mode 2 bit lasts 64 clocks, or 32 with baud doubling set.
// - Multiprocessor filtering drops received frames whose ninth bit is zero.
// - Receive enable clear stops the receiver in every mode.
// - Receive enable set allows async reception, starts sync reception in mode 0.
// - Modes 2 and 3 send the ninth transmit bit field as ninth bit.
// - Modes 2 and 3 store the received ninth bit in its field.
// - Mode 1 without filtering stores the stop bit there; mode 0 leaves it.
// - Mode 0 sets transmit done when the eighth bit is shifted out.
// - Async modes set transmit done when the last data bit ends.
// - Mode 0 sets receive done when the eighth bit completes.
// - Mode 1 sets receive done after the stop bit sample, per filtering.
// - Modes 2 and 3 set receive done after the ninth bit sample.
// - One buffer address: writes feed transmit, reads return the receive buffer.
module spo_serial_port (
    input  wire logic                  clock,
    input  wire logic                  reset,
    input  wire spo_pkg::spo_bus_req_s bus_req,
    output logic [7:0]                 rdata,
    input  wire logic                  timer1_overflow,
    input  wire logic                  rxd_in,
    output logic                       rxd_out,
    output logic                       rxd_oe,
    output logic                       txd,
    output logic                       irq
);
    import spo_pkg::*;

    spo_state_s r;
    spo_state_s n;
    logic       mode_a;
    logic       mode_b;
    logic       mp;
    logic       mode0;
    logic       mode2;
    logic       wr_ctl;
    logic       wr_buf;
    logic       wr_cfg;
    logic       tx_start;
    logic       m2_tick;
    logic       t1_tick;
    logic       tick;
    logic       tx_done;
    logic       rx_done;
    logic [3:0] sync_last;
    logic [3:0] sync_rise;
    logic [3:0] frame_last;

    // ----------------------------------------
    // Decode of mode and bus strobes
    // ----------------------------------------
    assign mode_a    = r.ctl.mode_select_bit_a;
    assign mode_b    = r.ctl.mode_select_bit_b;
    assign mp        = r.ctl.multiproc_or_rate_select;
    assign mode0     = !mode_a && !mode_b;
    assign mode2     = mode_a && !mode_b;
    assign wr_ctl    = bus_req.write && (bus_req.addr == SPO_ADDR_CTRL);
    assign wr_buf    = bus_req.write && (bus_req.addr == SPO_ADDR_BUF);
    assign wr_cfg    = bus_req.write && (bus_req.addr == SPO_ADDR_CFG);
    assign tx_start  = wr_buf && (r.tx_st == SPO_TX_IDLE) && (r.rx_st != SPO_RX_SYNC);
    // Sync period: 12 clocks, or 4 with the rate select bit set
    assign sync_last = mp ? SPO_SYNC_FAST_LAST : SPO_SYNC_SLOW_LAST;
    assign sync_rise = mp ? SPO_SYNC_FAST_RISE : SPO_SYNC_SLOW_RISE;
    // Frame length: 10 bits in mode 1, 11 bits in modes 2 and 3
    assign frame_last = mode_a ? SPO_FRAME11_LAST : SPO_FRAME10_LAST;

    // ----------------------------------------
    // Next-state logic
    // ----------------------------------------
    always_comb begin
        n       = r;
        m2_tick = 1'b0;
        t1_tick = 1'b0;
        tick    = 1'b0;
        tx_done = 1'b0;
        rx_done = 1'b0;

        // Two-flop synchroniser, then edge history
        n.sync1    = rxd_in;
        n.sync2    = r.sync1;
        n.rxd_prev = r.sync2;

        // Sixteenth-bit ticks: fixed prescale in mode 2, Timer 1 otherwise
        if (r.pre_cnt >= (r.dbl ? SPO_M2_FAST_PRE : SPO_M2_SLOW_PRE)) begin
            n.pre_cnt = 2'h0;
            m2_tick   = 1'b1;
        end else begin
            n.pre_cnt = r.pre_cnt + 2'h1;
        end
        if (timer1_overflow) begin
            n.ov_div = ~r.ov_div;
        end
        t1_tick = timer1_overflow && (r.dbl || r.ov_div);
        tick    = mode2 ? m2_tick : t1_tick;

        // Register writes and one-cycle read data
        n.rdata = 8'h00;
        if (bus_req.read) begin
            unique case (bus_req.addr)
                SPO_ADDR_CTRL:     n.rdata = r.ctl;
                SPO_ADDR_BUF:      n.rdata = r.rx_buf;
                SPO_ADDR_IRQ_STAT: n.rdata = {6'h00, r.irq_stat};
                SPO_ADDR_IRQ_MASK: n.rdata = {6'h00, r.irq_mask};
                SPO_ADDR_CFG:      n.rdata = {7'h00, r.dbl};
                default:           n.rdata = 8'h00;
            endcase
        end
        if (wr_ctl) begin
            n.ctl = spo_ctrl_s'(bus_req.wdata);
        end
        if (bus_req.write && (bus_req.addr == SPO_ADDR_IRQ_STAT)) begin
            n.irq_stat = r.irq_stat & ~bus_req.wdata[1:0];
        end
        if (bus_req.write && (bus_req.addr == SPO_ADDR_IRQ_MASK)) begin
            n.irq_mask = bus_req.wdata[1:0];
        end
        if (wr_cfg) begin
            n.dbl = bus_req.wdata[SPO_CFG_DOUBLE_POS];
        end

        // Transmitter
        unique case (r.tx_st)
            SPO_TX_IDLE: begin
                if (tx_start && mode0) begin
                    n.tx_st    = SPO_TX_SYNC;
                    n.tx_shift = {3'h7, bus_req.wdata};
                    n.tx_bits  = 4'h0;
                    n.tx_clk   = 4'h0;
                    n.rxd_oe   = 1'b1;
                    n.rxd_out  = bus_req.wdata[0];
                    n.txd      = 1'b0;
                end else if (tx_start) begin
                    n.tx_st    = SPO_TX_ASYNC;
                    // Start bit, data, ninth bit or stop, stop
                    n.tx_shift = {1'b1, mode_a ? r.ctl.ninth_transmit_bit : 1'b1,
                                  bus_req.wdata, 1'b0};
                    n.tx_bits  = 4'h0;
                    n.tx_tick  = 4'h0;
                    n.txd      = 1'b0;
                end
            end
            SPO_TX_ASYNC: begin
                if (tick) begin
                    n.tx_tick = r.tx_tick + 4'h1;
                    if (r.tx_tick == SPO_TICK_LAST) begin
                        n.tx_bits  = r.tx_bits + 4'h1;
                        n.tx_shift = {1'b1, r.tx_shift[10:1]};
                        n.txd      = r.tx_shift[1];
                        if (r.tx_bits == frame_last - 4'h1) begin
                            tx_done = 1'b1;
                        end
                        if (r.tx_bits == frame_last) begin
                            n.tx_st = SPO_TX_IDLE;
                            n.txd   = 1'b1;
                        end
                    end
                end
            end
            SPO_TX_SYNC: begin
                n.tx_clk = r.tx_clk + 4'h1;
                if (r.tx_clk == sync_rise) begin
                    n.txd = 1'b1;
                end
                if (r.tx_clk == sync_last) begin
                    n.tx_clk   = 4'h0;
                    n.tx_bits  = r.tx_bits + 4'h1;
                    n.tx_shift = {1'b1, r.tx_shift[10:1]};
                    if (r.tx_bits == SPO_SYNC_LAST) begin
                        tx_done  = 1'b1;
                        n.tx_st  = SPO_TX_IDLE;
                        n.rxd_oe = 1'b0;
                        n.txd    = 1'b1;
                    end else begin
                        n.rxd_out = r.tx_shift[1];
                        n.txd     = 1'b0;
                    end
                end
            end
            default: n.tx_st = SPO_TX_IDLE;
        endcase

        // Receiver; disabled receive aborts any frame in progress
        if (!r.ctl.receive_enable) begin
            n.rx_st = SPO_RX_IDLE;
            if (r.rx_st == SPO_RX_SYNC) begin
                n.txd = 1'b1;
            end
        end else begin
            unique case (r.rx_st)
                SPO_RX_IDLE: begin
                    if (mode0) begin
                        if (!r.ctl.receive_done_flag && (r.tx_st == SPO_TX_IDLE) && !wr_buf) begin
                            n.rx_st   = SPO_RX_SYNC;
                            n.rx_clk  = 4'h0;
                            n.rx_bits = 4'h0;
                            n.txd     = 1'b0;
                        end
                    end else if (r.rxd_prev && !r.sync2) begin
                        n.rx_st   = SPO_RX_START;
                        n.rx_tick = 4'h0;
                    end
                end
                SPO_RX_START: begin
                    if (tick) begin
                        n.rx_tick = r.rx_tick + 4'h1;
                        if (r.rx_tick == SPO_SAMPLE_TICK) begin
                            // A high start sample is a glitch
                            n.rx_st   = r.sync2 ? SPO_RX_IDLE : SPO_RX_DATA;
                            n.rx_bits = 4'h0;
                        end
                    end
                end
                SPO_RX_DATA: begin
                    if (tick) begin
                        n.rx_tick = r.rx_tick + 4'h1;
                        if (r.rx_tick == SPO_SAMPLE_TICK) begin
                            n.rx_shift = {r.sync2, r.rx_shift[8:1]};
                            n.rx_bits  = r.rx_bits + 4'h1;
                            if (r.rx_bits == SPO_RX_LAST) begin
                                // Last sample: stop bit or ninth bit
                                n.rx_st = SPO_RX_IDLE;
                                if (!r.ctl.receive_done_flag && (!mp || r.sync2)) begin
                                    rx_done                 = 1'b1;
                                    n.rx_buf                = r.rx_shift[8:1];
                                    n.ctl.ninth_receive_bit = r.sync2;
                                end
                            end
                        end
                    end
                end
                SPO_RX_SYNC: begin
                    n.rx_clk = r.rx_clk + 4'h1;
                    if (r.rx_clk == sync_rise) begin
                        n.txd      = 1'b1;
                        n.rx_shift = {r.sync2, r.rx_shift[8:1]};
                    end
                    if (r.rx_clk == sync_last) begin
                        n.rx_clk  = 4'h0;
                        n.rx_bits = r.rx_bits + 4'h1;
                        if (r.rx_bits == SPO_SYNC_LAST) begin
                            rx_done  = 1'b1;
                            n.rx_buf = r.rx_shift[8:1];
                            n.rx_st  = SPO_RX_IDLE;
                        end else begin
                            n.txd = 1'b0;
                        end
                    end
                end
                default: n.rx_st = SPO_RX_IDLE;
            endcase
        end

        // Hardware set wins over a software clear in the same cycle
        if (tx_done) begin
            n.ctl.transmit_done_flag      = 1'b1;
            n.irq_stat[SPO_IRQ_TX_POS]    = 1'b1;
        end
        if (rx_done) begin
            n.ctl.receive_done_flag       = 1'b1;
            n.irq_stat[SPO_IRQ_RX_POS]    = 1'b1;
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (reset) begin
            r          <= '0;
            r.ctl      <= spo_ctrl_s'(SPO_CTRL_RST);
            r.rx_buf   <= SPO_BUF_RST;
            r.irq_stat <= SPO_IRQ_RST;
            r.irq_mask <= SPO_IRQ_RST;
            r.dbl      <= SPO_CFG_RST;
            r.sync1    <= 1'b1;
            r.sync2    <= 1'b1;
            r.rxd_prev <= 1'b1;
            r.txd      <= 1'b1;
            r.tx_st    <= SPO_TX_IDLE;
            r.rx_st    <= SPO_RX_IDLE;
        end else begin
            r <= n;
        end
    end

    // Outputs
    assign rdata   = r.rdata;
    assign txd     = r.txd;
    assign rxd_out = r.rxd_out;
    assign rxd_oe  = r.rxd_oe;
    assign irq     = |(r.irq_stat & r.irq_mask);

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    // Tick spacing after the first quiet cycle of a slow period
    sequence s_gap_slow;
        !m2_tick ##1 !m2_tick ##1 m2_tick;
    endsequence

    // Slow tick with no config write able to change the rate mid-period
    sequence s_cfg_quiet;
        (m2_tick && !r.dbl && !wr_cfg) ##1 !wr_cfg [*2];
    endsequence

    property p_ren_off;
        !r.ctl.receive_enable |=> (r.rx_st == SPO_RX_IDLE);
    endproperty
    a_ren_off: assert property (p_ren_off)
        else $error("receiver active while disabled");

    property p_mp_filter;
        (rx_done && !mode0 && mp) |-> r.sync2;
    endproperty
    a_mp_filter: assert property (p_mp_filter)
        else $error("filtered frame raised receive done");

    property p_tb8;
        (tx_start && mode_a) |=> (r.tx_shift[9] == $past(r.ctl.ninth_transmit_bit));
    endproperty
    a_tb8: assert property (p_tb8)
        else $error("ninth transmit bit not loaded");

    property p_rb8_ninth;
        (rx_done && mode_a) |=> (r.ctl.ninth_receive_bit == $past(r.sync2))
            && r.ctl.receive_done_flag;
    endproperty
    a_rb8_ninth: assert property (p_rb8_ninth)
        else $error("ninth received bit not stored");

    property p_rb8_stop;
        (rx_done && !mode_a && mode_b && !mp) |=> (r.ctl.ninth_receive_bit == $past(r.sync2));
    endproperty
    a_rb8_stop: assert property (p_rb8_stop)
        else $error("stop bit not stored in mode 1");

    property p_m2_period;
        s_cfg_quiet |-> !$past(m2_tick) ##0 s_gap_slow;
    endproperty
    a_m2_period: assert property (p_m2_period)
        else $error("mode 2 tick spacing wrong");

    property p_async_ti;
        (tx_done && (r.tx_st == SPO_TX_ASYNC)) |=> r.ctl.transmit_done_flag && r.txd;
    endproperty
    a_async_ti: assert property (p_async_ti)
        else $error("transmit done not set before stop bit");

    property p_sync_ti;
        (tx_done && (r.tx_st == SPO_TX_SYNC)) |=> r.ctl.transmit_done_flag && !r.rxd_oe;
    endproperty
    a_sync_ti: assert property (p_sync_ti)
        else $error("mode 0 transmit end wrong");

    property p_start_bit;
        (tx_start && !mode0) |=> !r.txd [*8];
    endproperty
    a_start_bit: assert property (p_start_bit)
        else $error("start bit not held low");

    property p_buf_split;
        (wr_buf && !rx_done) |=> (r.rx_buf == $past(r.rx_buf));
    endproperty
    a_buf_split: assert property (p_buf_split)
        else $error("buffer write disturbed receive data");

endmodule
`default_nettype wire

// file: spo_remote_node.sv
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------
// Remote node driving the receive line
// ----------------------------------------
module spo_remote_node (
    input  wire logic clock,
    output logic      line
);
    // Line idles high between frames
    initial line = 1'b1;

    // One start bit, data LSB first, one stop bit
    task automatic send(input logic [8:0] data, input int nbits, input int per);
        logic [10:0] frm;
        frm = {1'b1, data, 1'b0};
        if (nbits == 8) frm[9] = 1'b1;
        for (int i = 0; i < nbits + 2; i++) begin
            @(posedge clock);
            line <= frm[i];
            repeat (per - 1) @(posedge clock);
        end
    endtask
endmodule

`default_nettype wire

// file: testbench.sv
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------
// Self-checking bench
// ----------------------------------------
module testbench;
    import spo_pkg::*;

    logic         clock;
    logic         reset;
    logic         timer1_overflow;
    logic         rxd_out;
    logic         rxd_oe;
    logic         txd;
    logic         irq;
    logic         node_line;
    logic         rxd_pin;
    logic [7:0]   rdata;
    logic [10:0]  frame;
    spo_bus_req_s bus_req;
    int           n_errors;
    int           num_checks;
    int           cycles;

    // Pin level: port drives in mode 0 transmit, else the node
    assign rxd_pin = rxd_oe ? rxd_out : node_line;

    spo_serial_port i_spo_serial_port (
        .clock           (clock),
        .reset           (reset),
        .bus_req         (bus_req),
        .rdata           (rdata),
        .timer1_overflow (timer1_overflow),
        .rxd_in          (rxd_pin),
        .rxd_out         (rxd_out),
        .rxd_oe          (rxd_oe),
        .txd             (txd),
        .irq             (irq)
    );

    spo_remote_node i_spo_remote_node (
        .clock (clock),
        .line  (node_line)
    );

    // Clock source
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // Overflow pulse every second clock, hang guard
    always @(posedge clock) begin
        cycles++;
        timer1_overflow <= ~timer1_overflow;
        if (cycles == 20000) begin
            n_errors++;
            close_out();
        end
    end

    task automatic close_out();
        if (n_errors == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        bus_req <= '{addr: a, wdata: d, write: 1'b1, read: 1'b0};
        @(posedge clock);
        bus_req.write <= 1'b0;
    endtask

    // Read one register and compare
    task automatic rc(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock);
        bus_req <= '{addr: a, wdata: 8'h00, write: 1'b0, read: 1'b1};
        @(posedge clock);
        bus_req.read <= 1'b0;
        #1 chk("register", rdata, exp);
    endtask

    task automatic frame_wait(input logic [8:0] d, input int nb);
        i_spo_remote_node.send(d, nb, 32);
        repeat (40) @(posedge clock);
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        reset = 1'b1;
        timer1_overflow = 1'b0;
        bus_req = '0;
        n_errors = 0;
        num_checks = 0;
        cycles = 0;
        repeat (20) @(posedge clock);
        reset <= 1'b0;
        // Reset values, unmapped place reads zero
        for (int a = 0; a < 6; a++) rc(8'hC0 + 8'(a), 8'h00);
        wr(SPO_ADDR_CTRL, 8'hFC);
        rc(SPO_ADDR_CTRL, 8'hFC);
        // Mode 2 transmit, doubled rate, ninth bit set
        wr(SPO_ADDR_CFG, 8'h01);
        wr(SPO_ADDR_IRQ_MASK, 8'h03);
        wr(SPO_ADDR_CTRL, 8'h88);
        wr(SPO_ADDR_BUF, 8'hA5);
        frame = {1'b1, 1'b1, 8'hA5, 1'b0};
        repeat (16) @(posedge clock);
        for (int i = 0; i < 11; i++) begin
            #1 chk("txd", {7'h00, txd}, {7'h00, frame[i]});
            if (i > 8) chk("irq", {7'h00, irq}, {7'h00, 1'(i == 10)});
            repeat (32) @(posedge clock);
        end
        rc(SPO_ADDR_CTRL, 8'h8A);
        rc(SPO_ADDR_IRQ_STAT, 8'h02);
        wr(SPO_ADDR_CTRL, 8'h88);
        wr(SPO_ADDR_IRQ_STAT, 8'h02);
        rc(SPO_ADDR_IRQ_STAT, 8'h00);
        chk("irq", {7'h00, irq}, 8'h00);
        // Mode 2 receive with address filtering
        wr(SPO_ADDR_CTRL, 8'hB0);
        frame_wait(9'h013, 9);
        rc(SPO_ADDR_CTRL, 8'hB0);
        frame_wait(9'h1C5, 9);
        rc(SPO_ADDR_CTRL, 8'hB5);
        rc(SPO_ADDR_BUF, 8'hC5);
        rc(SPO_ADDR_IRQ_STAT, 8'h01);
        chk("irq", {7'h00, irq}, 8'h01);
        wr(SPO_ADDR_CTRL, 8'h80);
        wr(SPO_ADDR_IRQ_STAT, 8'h03);
        // Receiver disabled ignores a frame
        frame_wait(9'h155, 9);
        rc(SPO_ADDR_CTRL, 8'h80);
        rc(SPO_ADDR_IRQ_STAT, 8'h00);
        // Mode 1 receive timed by overflow pulses
        wr(SPO_ADDR_CTRL, 8'h50);
        frame_wait(9'h13C, 8);
        rc(SPO_ADDR_CTRL, 8'h55);
        rc(SPO_ADDR_BUF, 8'h3C);
        // Mode 0 transmit, 4-clock bits
        wr(SPO_ADDR_CTRL, 8'h20);
        wr(SPO_ADDR_IRQ_STAT, 8'h03);
        wr(SPO_ADDR_BUF, 8'h6B);
        frame[7:0] = 8'h6B;
        repeat (3) @(posedge clock);
        for (int i = 0; i < 8; i++) begin
            #1 chk("shift clock", {7'h00, txd}, 8'h01);
            chk("shift data", {6'h00, rxd_oe, rxd_out}, {6'h00, 1'b1, frame[i]});
            repeat (2) @(posedge clock);
            if (i < 7) #1 chk("shift low", {7'h00, txd}, 8'h00);
            repeat (2) @(posedge clock);
        end
        repeat (8) @(posedge clock);
        #1 chk("shift release", {7'h00, rxd_oe}, 8'h00);
        rc(SPO_ADDR_CTRL, 8'h22);
        rc(SPO_ADDR_BUF, 8'h3C);
        close_out();
    end
endmodule

`default_nettype wire
